// >>> src/bfh_sequencer.sv
// Buck phase fault handling, hiccup timing and restart sequencer
// Contract
// - Over-temperature forces both gate drives off
// - Over-temperature pulls share bus and power-ok low
// - Hold share bus until over-temperature clears
// - After thermal release: straps, PLL lock, soft-start
// - Peak current limit kills high side immediately
// - Count OC cycles; two quiet cycles clear
// - Eight consecutive OC cycles enter hiccup
// - Average current over or under enters hiccup
// - Hiccup holds off 10ms then restarts
// - Diode emulation: zero crossing kills low side
// - Diode emulation forced during soft-start
// - Share bus low until own PLL locked
// - Fault pulls bus low; low bus stops drives
// - Up to six phases; strap selects shift
// - Master or follower synchronised with phase shift
// - Strap decodes emulation enable and phase delay
`timescale 1ns/1ps
`include "bfh_regs.svh"
module bfh_sequencer
   import bfh_pkg::*;
#(
   parameter int CLK_HZ    = `BFH_CLK_HZ,
   parameter int HICCUP_MS = `BFH_HICCUP_MS,
   parameter int HICCUP_CYC = (CLK_HZ / 1000) * HICCUP_MS,
   parameter int SS_STEPS  = 256
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Comparator flags, asynchronous
   input  wire logic       over_temp,
   input  wire logic       peak_oc,
   input  wire logic       avg_over,
   input  wire logic       avg_under,
   input  wire logic       zero_cross,
   input  wire logic       pll_locked,
   // Switching cycle and PWM requests
   input  wire logic       cycle_tick,
   input  wire logic       pwm_high,
   input  wire logic       pwm_low,
   // Straps
   input  wire logic [3:0] config_strap,
   input  wire logic [2:0] ss_strap,
   input  wire logic       master_sel,
   // Shared bus, open drain
   input  wire logic       share_bus_in,
   output logic            share_bus_out,
   output logic            share_bus_oe_n,
   // Outputs
   output logic            high_side_gate,
   output logic            low_side_gate,
   output logic            power_ok_out,
   output logic            diode_emulation,
   output bfh_pkg::bfh_phase_t phase_sel,
   output logic            phase_master,
   output logic [7:0]      soft_start_level,
   output logic [2:0]      ss_setting
);
   import bfh_pkg::*;

   initial begin
      if (HICCUP_CYC < 1 || SS_STEPS < 2 || SS_STEPS > 256)
         $error("bfh_sequencer: unsupported parameters");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and input synchronisers
   logic [1:0] rst_sync_q;
   logic       rst_n;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) rst_sync_q <= 2'b00;
      else       rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   localparam int NSYNC = 7;
   logic [NSYNC-1:0] s1_q, s2_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= {over_temp, peak_oc, avg_over, avg_under, zero_cross, pll_locked,
                  share_bus_in};
         s2_q <= s1_q;
      end
   end
   logic ot, poc, aov, aun, zc, lock, bus_hi;
   assign {ot, poc, aov, aun, zc, lock, bus_hi} = s2_q;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state
   bfh_state_t  st_q, st_d;
   logic [31:0] tmr_q, tmr_d;
   logic [3:0]  cfg_q, cfg_d;
   logic [2:0]  ss_q, ss_d;
   logic        mst_q, mst_d;
   logic [7:0]  lvl_q, lvl_d;
   logic        oc_trip, oc_clear;

   function automatic logic dem_of(input logic [3:0] c);
      return c[`BFH_CFG_DEM_BIT];
   endfunction

   always_comb begin
      st_d     = st_q;
      tmr_d    = tmr_q;
      cfg_d    = cfg_q;
      ss_d     = ss_q;
      mst_d    = mst_q;
      lvl_d    = lvl_q;
      oc_clear = 1'b0;
      if (ot) begin
         st_d  = BFH_ST_THERM;
         lvl_d = 8'h00;
      end else begin
         case (st_q)
            BFH_ST_THERM: begin
               st_d = BFH_ST_CFG;
            end
            BFH_ST_CFG: begin
               cfg_d    = config_strap;
               ss_d     = ss_strap;
               mst_d    = master_sel;
               lvl_d    = 8'h00;
               oc_clear = 1'b1;
               st_d     = BFH_ST_LOCK;
            end
            BFH_ST_LOCK: begin
               if (lock && bus_hi) st_d = BFH_ST_SOFT;
            end
            BFH_ST_SOFT: begin
               if (!bus_hi) begin
                  st_d = BFH_ST_HICCUP;
                  tmr_d = 32'h0;
               end else if (cycle_tick) begin
                  if (lvl_q == 8'(SS_STEPS - 1)) st_d = BFH_ST_RUN;
                  else lvl_d = lvl_q + 8'h01;
               end
            end
            BFH_ST_RUN: begin
               if (oc_trip || aov || aun || !bus_hi || !lock) begin
                  st_d  = BFH_ST_HICCUP;
                  tmr_d = 32'h0;
               end
            end
            BFH_ST_HICCUP: begin
               oc_clear = 1'b1;
               lvl_d    = 8'h00;
               if (tmr_q == 32'(HICCUP_CYC - 1)) st_d = BFH_ST_CFG;
               else tmr_d = tmr_q + 32'h1;
            end
            default: st_d = BFH_ST_CFG;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q  <= BFH_ST_CFG;
         tmr_q <= 32'h0;
         cfg_q <= 4'h0;
         ss_q  <= 3'h0;
         mst_q <= 1'b0;
         lvl_q <= 8'h00;
      end else begin
         st_q  <= st_d;
         tmr_q <= tmr_d;
         cfg_q <= cfg_d;
         ss_q  <= ss_d;
         mst_q <= mst_d;
         lvl_q <= lvl_d;
      end
   end

   bfh_oc_counter #(
      .LIMIT (`BFH_OC_LIMIT),
      .QUIET (`BFH_OC_QUIET)
   ) u_oc (
      .clk        (clk),
      .rst_n      (rst_n),
      .cycle_tick (cycle_tick),
      .oc_flag    (poc),
      .clear      (oc_clear),
      .oc_trip    (oc_trip)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Gate drives: combinational so peak current cuts the high side at once
   logic switching, dem_on, bus_low_drive;
   assign switching = (st_q == BFH_ST_SOFT) || (st_q == BFH_ST_RUN);
   // Emulation stays on while ramping regardless of strap
   assign dem_on = (st_q != BFH_ST_RUN) || dem_of(cfg_q);
   assign high_side_gate = switching && !ot && bus_hi && pwm_high && !poc;
   assign low_side_gate  = switching && !ot && bus_hi && pwm_low
                           && !(dem_on && zc);
   assign diode_emulation = dem_on;

   // Bus held low by fault, lock wait or restart; released once locked, before soft-start
   assign bus_low_drive = ot || (st_q == BFH_ST_THERM) || (st_q == BFH_ST_HICCUP)
                          || (st_q == BFH_ST_CFG) || !lock;
   assign share_bus_out  = 1'b0;
   assign share_bus_oe_n = !bus_low_drive;

   logic pok_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pok_q <= 1'b0;
      else        pok_q <= (st_q == BFH_ST_RUN) && !ot;
   end
   assign power_ok_out = pok_q && !ot;

   assign phase_sel        = bfh_phase_t'(cfg_q[`BFH_CFG_PH_MSB:`BFH_CFG_PH_LSB]);
   assign phase_master     = mst_q;
   assign soft_start_level = lvl_q;
   assign ss_setting       = ss_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_ot_gates_off: assert property (@(posedge clk) disable iff (!rst_n)
      ot |-> !high_side_gate && !low_side_gate) else $error("gates on in thermal");
   a_ot_bus_low: assert property (@(posedge clk) disable iff (!rst_n)
      ot |-> !share_bus_oe_n && !power_ok_out) else $error("bus released in thermal");
   a_ot_release: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(ot) |-> st_q == BFH_ST_THERM ##1 st_q == BFH_ST_CFG) else $error("no restart");
   a_peak_hs_off: assert property (@(posedge clk) disable iff (!rst_n)
      poc |-> !high_side_gate) else $error("high side on at peak");
   a_avg_hiccup: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == BFH_ST_RUN && (aov || aun) && !ot) |=> st_q == BFH_ST_HICCUP)
      else $error("no hiccup on average fault");
   a_hiccup_len: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == BFH_ST_HICCUP && tmr_q == 32'(HICCUP_CYC - 1) && !ot) |=> st_q == BFH_ST_CFG)
      else $error("hiccup length wrong");
   a_zc_ls_off: assert property (@(posedge clk) disable iff (!rst_n)
      (dem_on && zc) |-> !low_side_gate) else $error("low side on at zero cross");
   a_dem_soft: assert property (@(posedge clk) disable iff (!rst_n)
      st_q == BFH_ST_SOFT |-> diode_emulation) else $error("emulation off in soft-start");
   a_lock_bus: assert property (@(posedge clk) disable iff (!rst_n)
      !lock |-> !share_bus_oe_n) else $error("bus released before lock");
   a_bus_stop: assert property (@(posedge clk) disable iff (!rst_n)
      !bus_hi |-> !high_side_gate && !low_side_gate) else $error("drive with bus low");
   a_restart_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (st_q == BFH_ST_SOFT && $past(st_q) == BFH_ST_LOCK) |-> lvl_q == 8'h00)
      else $error("soft-start not from zero");

   c_thermal: cover property (@(posedge clk) disable iff (!rst_n) $fell(ot));
   c_oc_hiccup: cover property (@(posedge clk) disable iff (!rst_n)
      st_q == BFH_ST_RUN && oc_trip);
   c_run: cover property (@(posedge clk) disable iff (!rst_n) $rose(power_ok_out));
   c_restart: cover property (@(posedge clk) disable iff (!rst_n)
      st_q == BFH_ST_HICCUP ##1 st_q == BFH_ST_CFG);
endmodule : bfh_sequencer

// >>> src/bfh_regs.svh
// Constants for the buck fault and hiccup sequencer
`ifndef BFH_REGS_SVH
`define BFH_REGS_SVH
`define BFH_CLK_HZ        20000000
`define BFH_HICCUP_MS     10
`define BFH_OC_LIMIT      8
`define BFH_OC_QUIET      2
`define BFH_SS_STEP_MAX   8'hFF
`define BFH_CFG_DEM_BIT   3
`define BFH_CFG_PH_MSB    2
`define BFH_CFG_PH_LSB    0
`endif

// >>> src/bfh_pkg.sv
// Types for the buck fault and hiccup sequencer
package bfh_pkg;
   typedef enum logic [2:0] {
      BFH_ST_CFG    = 3'h0,
      BFH_ST_LOCK   = 3'h1,
      BFH_ST_SOFT   = 3'h3,
      BFH_ST_RUN    = 3'h2,
      BFH_ST_HICCUP = 3'h6,
      BFH_ST_THERM  = 3'h7
   } bfh_state_t;
   typedef enum logic [2:0] {
      BFH_PH_0 = 3'h0, BFH_PH_60 = 3'h1, BFH_PH_90 = 3'h2, BFH_PH_120 = 3'h3,
      BFH_PH_180 = 3'h4, BFH_PH_240 = 3'h5, BFH_PH_270 = 3'h6, BFH_PH_300 = 3'h7
   } bfh_phase_t;
endpackage : bfh_pkg

// >>> src/bfh_oc_counter.sv
// Peak overcurrent cycle counter with quiet-cycle clear
`timescale 1ns/1ps
`include "bfh_regs.svh"
module bfh_oc_counter #(
   parameter int LIMIT = `BFH_OC_LIMIT,
   parameter int QUIET = `BFH_OC_QUIET
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Switching cycle events
   input  wire logic cycle_tick,
   input  wire logic oc_flag,
   input  wire logic clear,
   // Result
   output logic      oc_trip
);
   initial begin
      if (LIMIT < 2 || LIMIT > 255 || QUIET < 1 || QUIET > 255)
         $error("bfh_oc_counter: unsupported LIMIT or QUIET");
   end

   logic [7:0] cnt_q, cnt_d;
   logic [7:0] quiet_q, quiet_d;
   logic       seen_q, seen_d;
   logic       trip_q, trip_d;

   always_comb begin
      cnt_d   = cnt_q;
      quiet_d = quiet_q;
      seen_d  = seen_q | oc_flag;
      trip_d  = trip_q;
      if (clear) begin
         cnt_d   = 8'h00;
         quiet_d = 8'h00;
         seen_d  = 1'b0;
         trip_d  = 1'b0;
      end else if (cycle_tick) begin
         seen_d = 1'b0;
         if (seen_q || oc_flag) begin
            quiet_d = 8'h00;
            if (cnt_q != 8'(LIMIT)) cnt_d = cnt_q + 8'h01;
            if (cnt_q == 8'(LIMIT - 1)) trip_d = 1'b1;
         end else begin
            if (quiet_q == 8'(QUIET - 1)) begin
               // A quiet clear ends the run of overcurrent cycles, so the trip goes too
               cnt_d   = 8'h00;
               quiet_d = 8'h00;
               trip_d  = 1'b0;
            end else begin
               quiet_d = quiet_q + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q   <= 8'h00;
         quiet_q <= 8'h00;
         seen_q  <= 1'b0;
         trip_q  <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         quiet_q <= quiet_d;
         seen_q  <= seen_d;
         trip_q  <= trip_d;
      end
   end

   assign oc_trip = trip_q;

   a_trip_after_limit: assert property (@(posedge clk) disable iff (!rst_n)
      trip_q |-> (cnt_q == 8'(LIMIT)) || $past(clear)) else $error("trip without full count");
endmodule : bfh_oc_counter

// >>> verification/bfh_peer_phase.sv
// Behavioural model of a paralleled peer phase on the shared current bus
`timescale 1ns/1ps
module bfh_peer_phase (
   // Clock
   clk,
   // Peer state commanded by the bench
   locked,
   fault,
   // Open-drain pull on the shared bus
   pull_low
);
   input  wire logic clk;
   input  wire logic locked;
   input  wire logic fault;
   output logic      pull_low;
   ////////////////////////////////////////////////////////////////////////////////
   // Bus stays held until the peer's own PLL locks; a peer fault holds it too
   always_ff @(posedge clk) begin
      pull_low <= !locked || fault;
   end
endmodule : bfh_peer_phase

// >>> verification/testbench.sv
// Self-checking bench for the buck fault and hiccup sequencer
`timescale 1ns/1ps
module testbench;
   import bfh_pkg::*;
   localparam int HIC = 50;
   logic       clk = 0, rstn = 0, over_temp = 0, peak_oc = 0, avg_over = 0, avg_under = 0;
   logic       zero_cross = 0, pll_locked = 0, cycle_tick = 0, pwm_high = 1, pwm_low = 1;
   logic       master_sel = 0, peer_locked = 0, peer_fault = 0, peer_pull;
   logic [3:0] config_strap = 4'h8;
   logic [2:0] ss_strap = 3'h5, tick_cnt = 3'h0, ss_setting;
   logic       share_bus_out, share_bus_oe_n, high_side_gate, low_side_gate;
   logic       power_ok_out, diode_emulation, phase_master;
   bfh_phase_t phase_sel;
   logic [7:0] soft_start_level;
   int         n_mismatch = 0, check_count = 0;
   // Released bus rises to the share voltage; any pull wins
   wire        share_bus = share_bus_oe_n & ~peer_pull;
   always #25 clk = ~clk;
   // One switching cycle every eight clocks
   always @(negedge clk) begin
      tick_cnt <= tick_cnt + 3'h1;
      cycle_tick <= (tick_cnt == 3'h7);
   end
   bfh_sequencer #(.HICCUP_CYC(HIC), .SS_STEPS(4)) DUT (
      .clk(clk), .rstn(rstn), .over_temp(over_temp), .peak_oc(peak_oc),
      .avg_over(avg_over), .avg_under(avg_under), .zero_cross(zero_cross),
      .pll_locked(pll_locked), .cycle_tick(cycle_tick), .pwm_high(pwm_high),
      .pwm_low(pwm_low), .config_strap(config_strap), .ss_strap(ss_strap),
      .master_sel(master_sel), .share_bus_in(share_bus), .share_bus_out(share_bus_out),
      .share_bus_oe_n(share_bus_oe_n), .high_side_gate(high_side_gate),
      .low_side_gate(low_side_gate), .power_ok_out(power_ok_out),
      .diode_emulation(diode_emulation), .phase_sel(phase_sel),
      .phase_master(phase_master), .soft_start_level(soft_start_level),
      .ss_setting(ss_setting));
   bfh_peer_phase peer (.clk(clk), .locked(peer_locked), .fault(peer_fault),
      .pull_low(peer_pull));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // Waits for power-ok, watching the soft-start ramp on the way
   task automatic go_run();
      bit   seen_one = 0;
      bit   pend = 0;
      logic pend_dem;
      for (int i = 0; i < 400; i++) begin
         cyc(1);
         if (power_ok_out === 1'b1) begin
            check("ramp_from_zero", seen_one, 1);
            return;
         end
         // The sample just before power-ok is already running, so judge one sample late
         if (pend) check("dem_in_ss", pend_dem, 1);
         if (soft_start_level === 8'h01) seen_one = 1;
         pend = (soft_start_level !== 8'h00);
         pend_dem = diode_emulation;
      end
      n_mismatch++;
      tally_and_finish();
   endtask : go_run
   task automatic do_reset();
      rstn = 0;
      pll_locked = 0;
      peer_locked = 0;
      cyc(2);
      rstn = 1;
      cyc(20);
      check("bus_before_lock", {share_bus_oe_n, power_ok_out}, 0);
      pll_locked = 1;
      cyc(10);
      check("peer_unlocked", {share_bus_oe_n, power_ok_out}, 8'h02);
      peer_locked = 1;
      go_run();
   endtask : do_reset
   // Fault already applied: gates off, hold-off length, then clean restart
   task automatic hiccup_check();
      int n = 0;
      while (power_ok_out !== 1'b0 && n < 100) begin
         cyc(1);
         n++;
      end
      if (n >= 100) n_mismatch++;
      check("fault_off", {high_side_gate, low_side_gate, share_bus_oe_n}, 0);
      {peak_oc, avg_over, avg_under, peer_fault} = 4'h0;
      n = 0;
      while (share_bus_oe_n !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      if (n >= 200) n_mismatch++;
      check("hiccup_len", (n >= HIC && n < HIC + 20), 1);
      go_run();
   endtask : hiccup_check
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_straps();
      for (int c = 0; c < 8; c++) begin
         config_strap = {c[0], c[2:0]};
         master_sel = c[1];
         ss_strap = c[2:0];
         do_reset();
         check("phase_sel", phase_sel, c);
         check("dem_after_ss", diode_emulation, c[0]);
         check("master", phase_master, c[1]);
         check("ss_setting", ss_setting, c);
      end
      config_strap = 4'h8;
      do_reset();
   endtask : test_straps
   task automatic test_zero_cross();
      check("low_on", low_side_gate, 1);
      zero_cross = 1;
      cyc(4);
      check("low_off_zc", low_side_gate, 0);
      zero_cross = 0;
      cyc(4);
   endtask : test_zero_cross
   task automatic test_peak();
      check("high_on", high_side_gate, 1);
      peak_oc = 1;
      cyc(3);
      check("high_off_oc", high_side_gate, 0);
      cyc(45);
      peak_oc = 0;
      cyc(24);
      peak_oc = 1;
      cyc(48);
      check("no_trip_split", power_ok_out, 1);
      hiccup_check();
   endtask : test_peak
   task automatic test_avg();
      for (int k = 0; k < 2; k++) begin
         if (k == 0) avg_over = 1;
         else avg_under = 1;
         hiccup_check();
      end
   endtask : test_avg
   task automatic test_thermal();
      over_temp = 1;
      peak_oc = 1;
      cyc(4);
      check("ot_outputs", {high_side_gate, low_side_gate, power_ok_out, share_bus_oe_n}, 0);
      cyc(100);
      check("ot_hold", {share_bus_oe_n, power_ok_out}, 0);
      check("bus_pull_level", share_bus_out, 0);
      peak_oc = 0;
      pll_locked = 0;
      over_temp = 0;
      cyc(20);
      check("relock_wait", {share_bus_oe_n, power_ok_out}, 0);
      pll_locked = 1;
      go_run();
   endtask : test_thermal
   initial begin
      test_straps();
      test_zero_cross();
      test_peak();
      test_avg();
      peer_fault = 1;
      hiccup_check();
      test_thermal();
      tally_and_finish();
   end
endmodule : testbench
